// file: core/csg_guard_bank.sv
// Read-before-write guard bank: three guarded registers, their shadows
// and the write-inhibit flag of the interrupt condition register.
// Assumes a synchronous 8-bit control bus on sys_clk; hardware events
// arrive on the same clock as one-cycle set/clear vectors.
//
// Functional notes
// RQ1: Transmit register read snapshots shadow.
// RQ2: Transmit write blocks stale bits, sets inhibit.
// RQ3: Receive A read snapshots shadow A.
// RQ4: Receive A write blocks stale bits, inhibit.
// RQ5: Receive B read snapshots shadow B.
// RQ6: Receive B write blocks stale bits, inhibit.
// RQ7: Transmit shadow mirrors all eight bits.
// RQ8: Shadow A mirrors all eight bits.
// RQ9: Shadow B mirrors all eight bits.
// RQ10: Host reads, then writes back read value.
// RQ11: Shadow holds until read or direct write.
`timescale 1ns/1ps
module csg_guard_bank
(
    // Clock and reset
    sys_clk,
    rst,
    // Control bus
    req,
    rdata,
    // Hardware events on guarded registers
    tx_evt,
    rxa_evt,
    rxb_evt,
    // Other hardware writes to the interrupt condition register
    int_set,
    // Register contents toward the rest of the device
    tx_state,
    rx_cond_a,
    rx_cond_b,
    int_cond
);
    input  wire logic               sys_clk;
    input  wire logic               rst;
    input  wire csg_pkg::csg_req_t  req;
    output logic [7:0]              rdata;
    input  wire csg_pkg::csg_hw_evt_t tx_evt;
    input  wire csg_pkg::csg_hw_evt_t rxa_evt;
    input  wire csg_pkg::csg_hw_evt_t rxb_evt;
    input  wire logic [7:0]         int_set;
    output logic [7:0]              tx_state;
    output logic [7:0]              rx_cond_a;
    output logic [7:0]              rx_cond_b;
    output logic [7:0]              int_cond;

    // Per-pair decode and state
    logic [2:0]       live_rd;
    logic [2:0]       live_wr;
    logic [2:0]       shadow_wr;
    logic [2:0]       inhibit;
    logic [7:0]       live_v   [3];
    logic [7:0]       shadow_v [3];
    logic [7:0]       set_v    [3];
    logic [7:0]       clr_v    [3];
    logic [5:0]       live_addr   [3];
    logic [5:0]       shadow_addr [3];

    // Interrupt condition register and read data
    logic [7:0]       int_cond_q;
    logic [7:0]       int_cond_d;
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;
    logic             int_wr;
    logic [7:0]       inhibit_bit;

    // Address table per guarded pair
    assign live_addr[csg_pkg::GUARD_TX]    = csg_pkg::TX_STATE_ADDR;
    assign live_addr[csg_pkg::GUARD_RXA]   = csg_pkg::RX_COND_A_ADDR;
    assign live_addr[csg_pkg::GUARD_RXB]   = csg_pkg::RX_COND_B_ADDR;
    assign shadow_addr[csg_pkg::GUARD_TX]  = csg_pkg::TX_SHADOW_ADDR;
    assign shadow_addr[csg_pkg::GUARD_RXA] = csg_pkg::RX_SHADOW_A_ADDR;
    assign shadow_addr[csg_pkg::GUARD_RXB] = csg_pkg::RX_SHADOW_B_ADDR;
    assign set_v[csg_pkg::GUARD_TX]  = tx_evt.set;
    assign clr_v[csg_pkg::GUARD_TX]  = tx_evt.clr;
    assign set_v[csg_pkg::GUARD_RXA] = rxa_evt.set;
    assign clr_v[csg_pkg::GUARD_RXA] = rxa_evt.clr;
    assign set_v[csg_pkg::GUARD_RXB] = rxb_evt.set;
    assign clr_v[csg_pkg::GUARD_RXB] = rxb_evt.clr;

    // One guard cell per pair
    genvar g;
    generate
        for (g = 0; g < csg_pkg::NUM_GUARD; g++)
        begin : g_pair
            // RQ1: RQ3: RQ5: read strobes snapshot
            assign live_rd[g]   = req.rd && (req.addr == live_addr[g]);
            // RQ2: RQ4: RQ6: guarded live write
            assign live_wr[g]   = req.wr && (req.addr == live_addr[g]);
            // RQ11: direct shadow write
            assign shadow_wr[g] = req.wr && (req.addr == shadow_addr[g]);
            // RQ7: RQ8: RQ9: full byte mirrored
            csg_guard_cell u_cell
            (
                .sys_clk   (sys_clk),
                .rst       (rst),
                .live_rd   (live_rd[g]),
                .live_wr   (live_wr[g]),
                .shadow_wr (shadow_wr[g]),
                .wdata     (req.wdata),
                .hw_set    (set_v[g]),
                .hw_clr    (clr_v[g]),
                .live_q    (live_v[g]),
                .shadow_q  (shadow_v[g]),
                .inhibit   (inhibit[g])
            );
        end
    endgenerate

    // Host write loads the interrupt register with wdata; sets win
    assign int_wr = req.wr && (req.addr == csg_pkg::INT_COND_ADDR);
    // RQ2: RQ4: RQ6: inhibit flag raised
    assign inhibit_bit = (|inhibit) ? (8'h01 << csg_pkg::WRITE_INHIBIT_BIT) : 8'h00;
    assign int_cond_d  = (int_wr ? req.wdata : int_cond_q) | int_set | inhibit_bit;

    // Read mux, registered so the output is a flop
    always_comb
    begin
        rdata_d = 8'h00;
        case (req.addr)
            csg_pkg::TX_STATE_ADDR:    rdata_d = live_v[csg_pkg::GUARD_TX];
            csg_pkg::RX_COND_A_ADDR:   rdata_d = live_v[csg_pkg::GUARD_RXA];
            csg_pkg::RX_COND_B_ADDR:   rdata_d = live_v[csg_pkg::GUARD_RXB];
            csg_pkg::TX_SHADOW_ADDR:   rdata_d = shadow_v[csg_pkg::GUARD_TX];
            csg_pkg::RX_SHADOW_A_ADDR: rdata_d = shadow_v[csg_pkg::GUARD_RXA];
            csg_pkg::RX_SHADOW_B_ADDR: rdata_d = shadow_v[csg_pkg::GUARD_RXB];
            csg_pkg::INT_COND_ADDR:    rdata_d = int_cond_q;
            default:                   rdata_d = 8'h00;
        endcase
    end

    // Interrupt register and read data flops
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            int_cond_q <= csg_pkg::INT_COND_RESET;
            rdata_q    <= 8'h00;
        end
        else
        begin
            int_cond_q <= int_cond_d;
            rdata_q    <= req.rd ? rdata_d : rdata_q;
        end
    end

    assign rdata     = rdata_q;
    assign int_cond  = int_cond_q;
    assign tx_state  = live_v[csg_pkg::GUARD_TX];
    assign rx_cond_a = live_v[csg_pkg::GUARD_RXA];
    assign rx_cond_b = live_v[csg_pkg::GUARD_RXB];

endmodule // csg_guard_bank

// file: core/csg_guard_cell.sv
// One guarded register with its comparison shadow.
// Assumes the parent decodes the bus and gives single-cycle strobes.
`timescale 1ns/1ps
module csg_guard_cell
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // Bus strobes already decoded for this pair
    input  wire logic       live_rd,
    input  wire logic       live_wr,
    input  wire logic       shadow_wr,
    input  wire logic [7:0] wdata,
    // Hardware events on the live register
    input  wire logic [7:0] hw_set,
    input  wire logic [7:0] hw_clr,
    // State
    output logic [7:0]      live_q,
    output logic [7:0]      shadow_q,
    output logic            inhibit
);

    // Bits whose live value has moved since the snapshot
    logic [7:0] stale;
    // Bits the host may change on this write
    logic [7:0] wr_mask;
    // Next values
    logic [7:0] live_d;
    logic [7:0] shadow_d;

    assign stale   = live_q ^ shadow_q;
    assign wr_mask = live_wr ? ~stale : 8'h00;
    // Inhibit when a stale bit would be set or cleared by the host
    assign inhibit = live_wr && (|(stale & (wdata ^ live_q)));

    // Hardware sets win over a host write in the same cycle
    assign live_d = (((live_q & ~wr_mask) | (wdata & wr_mask)) & ~hw_clr) | hw_set;

    // Shadow: snapshot on read, direct store on its own write
    assign shadow_d = live_rd ? live_q : (shadow_wr ? wdata : shadow_q);

    // Register update
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            live_q   <= csg_pkg::RX_COND_RESET;
            shadow_q <= csg_pkg::SHADOW_RESET;
        end
        else
        begin
            live_q   <= live_d;
            shadow_q <= shadow_d;
        end
    end

endmodule // csg_guard_cell

// file: core/csg_pkg.sv
// Package for the compare-shadow write guard block.
// Assumes an 8-bit control bus with a 6-bit register address on one clock.
package csg_pkg;

    // Control bus address width and data width
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;

    // Guarded live registers (paired with the shadows)
    localparam logic [5:0] TX_STATE_ADDR      = 6'h04;
    localparam logic [5:0] RX_COND_A_ADDR     = 6'h0A;
    localparam logic [5:0] RX_COND_B_ADDR     = 6'h0B;
    // Interrupt condition register holding the inhibit flag
    localparam logic [5:0] INT_COND_ADDR      = 6'h02;
    // Shadow registers
    localparam logic [5:0] TX_SHADOW_ADDR     = 6'h1B;
    localparam logic [5:0] RX_SHADOW_A_ADDR   = 6'h1C;
    localparam logic [5:0] RX_SHADOW_B_ADDR   = 6'h1D;

    // Bit position of the write-inhibit flag in the interrupt condition register
    localparam int WRITE_INHIBIT_BIT = 3;

    // Reset values
    localparam logic [7:0] TX_STATE_RESET  = 8'h00;
    localparam logic [7:0] RX_COND_RESET   = 8'h00;
    localparam logic [7:0] SHADOW_RESET    = 8'h00;
    localparam logic [7:0] INT_COND_RESET  = 8'h00;

    // Number of guarded register pairs
    localparam int NUM_GUARD = 3;
    localparam int GUARD_TX  = 0;
    localparam int GUARD_RXA = 1;
    localparam int GUARD_RXB = 2;

    // Bus request from the station-management processor
    typedef struct packed {
        logic                rd;
        logic                wr;
        logic [5:0]          addr;
        logic [7:0]          wdata;
    } csg_req_t;

    // Device-side per-register event (hardware set / clear)
    typedef struct packed {
        logic [7:0]          set;
        logic [7:0]          clr;
    } csg_hw_evt_t;

endpackage

// file: testbench/csg_guard_bank_assertions.sv
// Port checker for the guard bank.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/1ps
module csg_bank_chk
(
    // Clock and reset
    input wire logic                 sys_clk,
    input wire logic                 rst,
    // Bus and registers
    input wire csg_pkg::csg_req_t    req,
    input wire logic [7:0]           rdata,
    input wire csg_pkg::csg_hw_evt_t tx_evt,
    input wire logic [7:0]           tx_state,
    input wire logic [7:0]           rx_cond_a,
    input wire logic [7:0]           rx_cond_b,
    input wire logic [7:0]           int_cond
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Bus strobes aimed at one address
    sequence s_rd(a); req.rd && req.addr == a; endsequence
    sequence s_wr(a); req.wr && req.addr == a; endsequence
    a_tx_rd_data: assert property (s_rd(csg_pkg::TX_STATE_ADDR) |=> rdata == $past(tx_state))
        else $error("transmit read data wrong");
    a_rxb_rd_data: assert property (s_rd(csg_pkg::RX_COND_B_ADDR) |=> rdata == $past(rx_cond_b))
        else $error("receive b read data wrong");
    a_tx_snap: assert property (s_rd(csg_pkg::TX_STATE_ADDR) ##1 s_rd(csg_pkg::TX_SHADOW_ADDR)
        |=> rdata == $past(tx_state, 2)) else $error("transmit shadow not loaded");
    a_rxa_snap: assert property (s_rd(csg_pkg::RX_COND_A_ADDR) ##1 s_rd(csg_pkg::RX_SHADOW_A_ADDR)
        |=> rdata == $past(rx_cond_a, 2)) else $error("shadow a not loaded");
    a_rxb_snap: assert property (s_rd(csg_pkg::RX_COND_B_ADDR) ##1 s_rd(csg_pkg::RX_SHADOW_B_ADDR)
        |=> rdata == $past(rx_cond_b, 2)) else $error("shadow b not loaded");
    a_shadow_store: assert property (s_wr(csg_pkg::TX_SHADOW_ADDR) ##1 s_rd(csg_pkg::TX_SHADOW_ADDR)
        |=> rdata == $past(req.wdata, 2)) else $error("shadow write lost");
    // Fresh snapshot means nothing is stale, so the write lands whole
    a_clean_write: assert property ((req.rd && req.addr == csg_pkg::TX_STATE_ADDR && tx_evt == 16'h0000)
        ##1 (req.wr && req.addr == csg_pkg::TX_STATE_ADDR && tx_evt == 16'h0000)
        |=> tx_state == $past(req.wdata)) else $error("clean write blocked");
    a_inhibit_hold: assert property (int_cond[3] && !(req.wr && req.addr == csg_pkg::INT_COND_ADDR)
        |=> int_cond[3]) else $error("inhibit flag dropped");
endmodule // csg_bank_chk

bind csg_guard_bank csg_bank_chk u_chk (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
    .tx_evt(tx_evt), .tx_state(tx_state), .rx_cond_a(rx_cond_a), .rx_cond_b(rx_cond_b),
    .int_cond(int_cond));

// file: testbench/csg_host.sv
// Station-management host on the control bus.
// Assumes bus() is called just after a rising edge.
`timescale 1ns/1ps
module csg_host
(
    // Clock
    input wire logic          sys_clk,
    // Request toward the device
    output csg_pkg::csg_req_t req
);
    // Idle bus from time zero
    initial req = '0;
    // One request, taken at the next edge
    task automatic bus(input logic r, input logic w, input logic [5:0] a, input logic [7:0] d);
        req <= '{rd: r, wr: w, addr: a, wdata: d};
        @(posedge sys_clk);
    endtask
endmodule // csg_host

// file: testbench/testbench.sv
// Self-checking bench for the guard bank with a reference model.
// Assumes the host model owns the control bus.
`timescale 1ns/1ps
module testbench;
    logic                 sys_clk, rst, run;
    csg_pkg::csg_req_t    req;
    csg_pkg::csg_hw_evt_t evt [3];
    logic [7:0]           rdata, tx_state, rx_cond_a, rx_cond_b, int_cond;
    logic [7:0]           live [3], sh [3], interrupt_condition_register, exp_rd, iset;
    int                   error_cnt, checks, cyc;
    localparam logic [5:0] LA [3] = '{csg_pkg::TX_STATE_ADDR, csg_pkg::RX_COND_A_ADDR,
                                      csg_pkg::RX_COND_B_ADDR};
    localparam logic [5:0] SA [3] = '{csg_pkg::TX_SHADOW_ADDR, csg_pkg::RX_SHADOW_A_ADDR,
                                      csg_pkg::RX_SHADOW_B_ADDR};
    csg_guard_bank dut (.sys_clk(sys_clk), .rst(rst), .req(req), .rdata(rdata),
        .tx_evt(evt[0]), .rxa_evt(evt[1]), .rxb_evt(evt[2]), .int_set(iset),
        .tx_state(tx_state), .rx_cond_a(rx_cond_a), .rx_cond_b(rx_cond_b), .int_cond(int_cond));
    csg_host host (.sys_clk(sys_clk), .req(req));
    initial
    begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin error_cnt++; $display("[FAIL] %0t got %h exp %h", $time, got, exp); end
    endtask
    task automatic finish_test();
        $display("error_cnt %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One bus op or device event, then the model follows
    task automatic op(input int k, input int g, input logic [7:0] d, input logic [7:0] e);
        logic [7:0] blk;
        for (int i = 0; i < 3; i++) evt[i] <= (k == 4 && i == g) ? {d, e & ~d} : 16'h0000;
        // Other interrupt sources fire alongside device events
        iset <= (k == 4) ? e : 8'h00;
        case (k)
            0: begin host.bus(1, 0, LA[g], 0); exp_rd = live[g]; sh[g] = live[g]; end
            1: begin host.bus(1, 0, SA[g], 0); exp_rd = sh[g]; end
            2: begin host.bus(0, 1, LA[g], d); blk = (live[g] ^ sh[g]) & (d ^ live[g]);
                live[g] = (d & ~blk) | (live[g] & blk);
                if (blk != 0) interrupt_condition_register[csg_pkg::WRITE_INHIBIT_BIT] = 1; end
            3: begin host.bus(0, 1, SA[g], d); sh[g] = d; end
            4: begin host.bus(0, 0, 0, 0); live[g] = (live[g] | d) & ~(e & ~d); interrupt_condition_register = interrupt_condition_register | e; end
            5: begin host.bus(1, 0, csg_pkg::INT_COND_ADDR, 0); exp_rd = interrupt_condition_register; end
            6: begin host.bus(0, 1, csg_pkg::INT_COND_ADDR, d); interrupt_condition_register = d; end
            default: begin host.bus(1, 0, 6'h3F, 0); exp_rd = 0; end
        endcase
    endtask
    // Compare every settled cycle against the model
    always @(negedge sys_clk)
    begin
        if (run)
        begin
            chk(tx_state, live[0]);
            chk(rx_cond_a, live[1]);
            chk(rx_cond_b, live[2]);
            chk(int_cond, interrupt_condition_register);
            chk(rdata, exp_rd);
        end
    end
    // Hang guard
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin error_cnt++; finish_test(); end
    end
    initial
    begin
        rst = 1; run = 0; error_cnt = 0; checks = 0; cyc = 0; exp_rd = 0; interrupt_condition_register = 0; iset = 0;
        for (int i = 0; i < 3; i++) begin evt[i] = '0; live[i] = 0; sh[i] = 0; end
        void'($urandom(32'h0677448e));
        repeat (20) @(posedge sys_clk);
        rst <= 0;
        @(posedge sys_clk);
        run = 1;
        for (int g = 0; g < 3; g++)
        begin
            op(3, g, 8'hA5, 0); op(1, g, 0, 0);
            op(0, g, 0, 0); op(1, g, 0, 0);
            op(4, g, 8'h3C, 8'hC3); op(2, g, 8'h00, 0);
            op(0, g, 0, 0); op(2, g, ~live[g], 0);
            op(6, g, 0, 0);
        end
        repeat (600) op($urandom_range(7), $urandom_range(2), 8'($urandom), 8'($urandom));
        @(posedge sys_clk);
        finish_test();
    end
endmodule // testbench
